//--- fwbce_ctrl.sv
// host controller issuing buffered-program command entry to a parallel flash
`timescale 1ns/10ps
// Operation
// [R1] after unlock, write the buffer-load code then the word count to the sector address.
// [R2] after the count, write each location with its value, the last to the final buffer location.
// [R3] commit the buffer with one write of the confirm code to the sector address.
// [R4] with chip enable held low, upper address bits from 12 up stay fixed from command to confirm.
// [R5] the device offers no elevated-voltage identification mode, so none is driven here.
// [R6] before the buffer-load command, write the two unlock codes to the two unlock addresses.
module fwbce_ctrl
  import fwbce_pkg::*;
#(
  parameter int unsigned DEPTH = 16
)(
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              start,
  input  wire logic [ADDR_W-1:0] sector_select_address,
  input  wire logic [4:0]        load_word_count,
  input  wire logic [ADDR_W-1:0] program_location,
  input  wire logic [DATA_W-1:0] program_value,
  output logic                   word_req,
  output logic                   busy,
  output logic                   done,
  output logic [ADDR_W-1:0]      flash_addr,
  output logic [DATA_W-1:0]      flash_dq_out,
  output logic                   flash_dq_oe,
  output logic                   flash_ce_n,
  output logic                   flash_we_n,
  output logic                   flash_oe_n
);
  localparam logic [3:0] STROBE_LAST = 4'(STROBE_CYC - 1);
  localparam logic [3:0] SETUP_LAST  = 4'(SETUP_CYC);

  fwbce_state_t      st_r, st_nxt;
  logic [4:0]        left_r, left_nxt;
  logic [3:0]        tm_r, tm_nxt;
  logic              ph_r, ph_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt, sect_r, sect_nxt;
  logic [DATA_W-1:0] dq_r, dq_nxt;
  logic              we_r, we_nxt, ce_r, ce_nxt, oe_r, oe_nxt;
  logic              req_r, req_nxt, done_r, done_nxt;
  logic              busy_r, busy_nxt, rd_n_r, rd_n_nxt;
  logic              cyc_end;

  // each bus cycle: address setup phase, then we low for strobe time
  assign cyc_end = ph_r && (tm_r == STROBE_LAST);

  always_comb
  begin
    st_nxt   = st_r;
    left_nxt = left_r;
    tm_nxt   = tm_r + 4'h1;
    ph_nxt   = ph_r;
    addr_nxt = addr_r;
    sect_nxt = sect_r;
    dq_nxt   = dq_r;
    we_nxt   = we_r;
    ce_nxt   = ce_r;
    oe_nxt   = oe_r;
    req_nxt  = 1'b0;
    done_nxt = 1'b0;
    // reads are never issued; no elevated id voltage pin exists here
    rd_n_nxt = 1'b1; // R5
    if (!ph_r && tm_r == SETUP_LAST && st_r != FWBCE_IDLE && st_r != FWBCE_WAITW)
    begin
      ph_nxt = 1'b1;
      we_nxt = 1'b0;
      tm_nxt = 4'h0;
    end
    if (cyc_end)
    begin
      ph_nxt = 1'b0;
      we_nxt = 1'b1;
      tm_nxt = 4'h0;
    end
    case (st_r)
      FWBCE_IDLE:
      begin
        ce_nxt = 1'b1;
        oe_nxt = 1'b0;
        tm_nxt = 4'h0;
        if (start)
        begin
          st_nxt   = FWBCE_UNLK1;
          sect_nxt = sector_select_address;
          left_nxt = load_word_count;
          addr_nxt = UNLOCK1_ADDR; // R6
          dq_nxt   = UNLOCK1_CODE; // R6
          ce_nxt   = 1'b0;
          oe_nxt   = 1'b1;
        end
      end
      FWBCE_UNLK1:
        if (cyc_end)
        begin
          st_nxt   = FWBCE_UNLK2;
          addr_nxt = UNLOCK2_ADDR; // R6
          dq_nxt   = UNLOCK2_CODE; // R6
        end
      FWBCE_UNLK2:
        if (cyc_end)
        begin
          st_nxt   = FWBCE_CMD;
          addr_nxt = sect_r; // R1
          dq_nxt   = BUF_LOAD_CODE; // R1
        end
      FWBCE_CMD:
        if (cyc_end)
        begin
          st_nxt = FWBCE_COUNT;
          dq_nxt = {11'h000, left_r}; // R1
        end
      FWBCE_COUNT:
        if (cyc_end)
        begin
          st_nxt  = FWBCE_WAITW;
          req_nxt = 1'b1;
        end
      FWBCE_WAITW:
      begin
        tm_nxt = 4'h0;
        // upper bits forced from the sector keep them fixed under low ce
        addr_nxt = {sect_r[ADDR_W-1:SECT_LSB], program_location[SECT_LSB-1:0]}; // R4
        dq_nxt   = program_value; // R2
        st_nxt   = FWBCE_LOAD;
      end
      FWBCE_LOAD:
        if (cyc_end)
        begin
          if (left_r == CNT_ZERO)
          begin
            st_nxt   = FWBCE_CONF;
            addr_nxt = sect_r; // R3
            dq_nxt   = CONFIRM_CODE; // R3
          end
          else
          begin
            left_nxt = left_r - CNT_ONE; // R2
            st_nxt   = FWBCE_WAITW;
            req_nxt  = 1'b1;
          end
        end
      FWBCE_CONF:
        if (cyc_end)
        begin
          st_nxt   = FWBCE_IDLE; // R3
          done_nxt = 1'b1;
          ce_nxt   = 1'b1;
          oe_nxt   = 1'b0;
        end
      default:
        st_nxt = FWBCE_IDLE;
    endcase
    // registered so busy leaves a flop, same timing as the state decode
    busy_nxt = (st_nxt != FWBCE_IDLE);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r   <= FWBCE_IDLE;
      left_r <= 5'h00;
      tm_r   <= 4'h0;
      ph_r   <= 1'b0;
      addr_r <= '0;
      sect_r <= '0;
      dq_r   <= '0;
      we_r   <= 1'b1;
      ce_r   <= 1'b1;
      oe_r   <= 1'b0;
      req_r  <= 1'b0;
      done_r <= 1'b0;
      busy_r <= 1'b0;
      rd_n_r <= 1'b1;
    end
    else
    begin
      st_r   <= st_nxt;
      left_r <= left_nxt;
      tm_r   <= tm_nxt;
      ph_r   <= ph_nxt;
      addr_r <= addr_nxt;
      sect_r <= sect_nxt;
      dq_r   <= dq_nxt;
      we_r   <= we_nxt;
      ce_r   <= ce_nxt;
      oe_r   <= oe_nxt;
      req_r  <= req_nxt;
      done_r <= done_nxt;
      busy_r <= busy_nxt;
      rd_n_r <= rd_n_nxt;
    end
  end

  assign flash_oe_n   = rd_n_r; // R5
  assign word_req     = req_r;
  assign busy         = busy_r;
  assign done         = done_r;
  assign flash_addr   = addr_r;
  assign flash_dq_out = dq_r;
  assign flash_dq_oe  = oe_r;
  assign flash_ce_n   = ce_r;
  assign flash_we_n   = we_r;

  a_sector_hold: assert property (@(posedge clk) disable iff (!rstn)
    (st_r inside {FWBCE_CMD, FWBCE_COUNT, FWBCE_WAITW, FWBCE_LOAD, FWBCE_CONF} && !flash_ce_n)
    |-> flash_addr[ADDR_W-1:SECT_LSB] == sect_r[ADDR_W-1:SECT_LSB])
    else $error("sector bits moved during load"); // R4
  a_confirm_addr: assert property (@(posedge clk) disable iff (!rstn)
    (st_r == FWBCE_CONF) |-> (flash_addr == sect_r && flash_dq_out == CONFIRM_CODE))
    else $error("confirm not at sector"); // R3
  a_cmd_code: assert property (@(posedge clk) disable iff (!rstn)
    (st_r == FWBCE_CMD) |-> (flash_addr == sect_r && flash_dq_out == BUF_LOAD_CODE))
    else $error("bad buffer-load cycle"); // R1
  a_unlock_first: assert property (@(posedge clk) disable iff (!rstn)
    (st_r == FWBCE_UNLK1) |-> (flash_addr == UNLOCK1_ADDR && flash_dq_out == UNLOCK1_CODE))
    else $error("bad first unlock"); // R6
  a_unlock_order: assert property (@(posedge clk) disable iff (!rstn)
    (st_r == FWBCE_UNLK2) |-> $past(st_r) inside {FWBCE_UNLK1, FWBCE_UNLK2})
    else $error("second unlock out of order"); // R6
  a_count_follow: assert property (@(posedge clk) disable iff (!rstn)
    (st_r == FWBCE_COUNT && $past(st_r) == FWBCE_CMD) |-> flash_dq_out[4:0] == left_r)
    else $error("count not written"); // R1
  a_load_value: assert property (@(posedge clk) disable iff (!rstn)
    $rose(st_r == FWBCE_LOAD) |-> flash_dq_out == $past(program_value))
    else $error("load value lost"); // R2
  a_done_pulse: assert property (@(posedge clk) disable iff (!rstn)
    done |-> ##1 !done)
    else $error("done longer than one cycle"); // R3
  c_full_seq: cover property (@(posedge clk) disable iff (!rstn) done);
  c_start: cover property (@(posedge clk) disable iff (!rstn) start && !busy);
  c_load: cover property (@(posedge clk) disable iff (!rstn) st_r == FWBCE_LOAD && left_r != 5'h00);
endmodule // fwbce_ctrl

//--- fwbce_ctrl_tb_top.sv
// testbench for the flash write buffer command entry controller
`timescale 1ns/10ps
module fwbce_ctrl_tb_top;
  import fwbce_pkg::*;
  logic              clk, rstn, start, word_req, busy, done, dq_oe, ce_n, we_n, oe_n;
  logic [ADDR_W-1:0] sa, loc, addr;
  logic [DATA_W-1:0] val, dq;
  logic [4:0]        cnt;
  int                fail_count = 0;
  int                comparisons = 0;

  fwbce_ctrl dut (.clk(clk), .rstn(rstn), .start(start), .sector_select_address(sa),
    .load_word_count(cnt), .program_location(loc), .program_value(val),
    .word_req(word_req), .busy(busy), .done(done), .flash_addr(addr), .flash_dq_out(dq),
    .flash_dq_oe(dq_oe), .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n));
  fwbce_flash_model flash (.flash_addr(addr), .flash_dq_out(dq), .flash_dq_oe(dq_oe),
    .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // poke raises start mid-run with another sector; it must be ignored
  task automatic run_seq(input logic [ADDR_W-1:0] s, input logic [4:0] n, input bit poke);
    int k, t, base;
    logic req;
    logic [ADDR_W-1:0] ea;
    logic [DATA_W-1:0] ed;
    k = 0;
    t = 0;
    base = flash.log_a.size();
    @(posedge clk);
    sa <= s;
    cnt <= n;
    start <= 1'b1;
    // the controller takes a word at the edge that ends word_req, so one is shown ahead
    loc <= {~s[21:12], 12'h000};
    val <= 16'h1000;
    @(posedge clk);
    start <= 1'b0;
    while (t < 2000)
    begin
      @(negedge clk);
      t++;
      if (done === 1'b1)
        break;
      req = word_req;
      if (t == 6)
        check(32'(busy), 32'h1);
      @(posedge clk);
      if (poke)
        start <= (t == 6);
      if (poke && t == 6)
        sa <= ~s;
      if (req === 1'b1)
      begin
        // upper bits wrong on purpose: the controller must force the sector
        k++;
        loc <= {~s[21:12], 12'(k * 3)};
        val <= 16'(16'h1000 + k);
      end
    end
    check(32'(t < 2000), 32'h1);
    check(32'(ce_n), 32'h1);
    check(32'(busy), 32'h0);
    check(32'(dq_oe), 32'h0);
    check(32'(k), 32'(n) + 1);
    check(32'(flash.log_a.size() - base), 32'(n) + 6);
    check(32'(flash.log_a[base + 1]), 32'(UNLOCK2_ADDR));
    for (int i = 0; i < n + 6; i++)
    begin
      ea = (i < 4 || i == n + 5) ? s : {s[21:12], 12'((i - 4) * 3)};
      ed = (i == n + 5) ? CONFIRM_CODE : 16'(16'h1000 + i - 4);
      case (i)
        0: begin ea = UNLOCK1_ADDR; ed = UNLOCK1_CODE; end
        1: begin ea = UNLOCK2_ADDR; ed = UNLOCK2_CODE; end
        2: ed = BUF_LOAD_CODE;
        3: ed = 16'(n);
        default: ;
      endcase
      check(32'(flash.log_a[base + i]), 32'(ea));
      check(32'(flash.log_d[base + i]), 32'(ed));
    end
    check(32'(flash.mem[{s[21:12], 12'(n * 3)}]), 32'h1000 + 32'(n));
  endtask

  task automatic t_single();
    run_seq(22'h123456, 5'h00, 1'b0);
    $display("test single word done");
  endtask

  task automatic t_full_refused();
    run_seq(22'h3ff000, 5'h0f, 1'b1);
    $display("test full buffer with refused start done");
  endtask

  task automatic t_back_to_back();
    run_seq(22'h000abc, 5'h03, 1'b0);
    run_seq(22'h2a5fff, 5'h1f, 1'b0);
    $display("test back to back done");
  endtask

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial
  begin
    #20000;
    fail_count++;
    wrap_up();
  end

  initial
  begin
    rstn = 1'b0;
    start = 1'b0;
    sa = '0;
    cnt = '0;
    loc = '0;
    val = '0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    check(32'({ce_n, we_n, oe_n, busy}), 32'he);
    t_single();
    t_full_refused();
    t_back_to_back();
    wrap_up();
  end
endmodule // fwbce_ctrl_tb_top

//--- fwbce_flash_model.sv
// behavioural flash device that logs writes and programs its buffer on confirm
`timescale 1ns/10ps
module fwbce_flash_model
  import fwbce_pkg::*;
(
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic [DATA_W-1:0] flash_dq_out,
  input wire logic              flash_dq_oe,
  input wire logic              flash_ce_n,
  input wire logic              flash_we_n,
  input wire logic              flash_oe_n
);
  logic [ADDR_W-1:0] log_a[$];
  logic [DATA_W-1:0] log_d[$];
  logic [DATA_W-1:0] mem[logic [ADDR_W-1:0]];
  logic [ADDR_W-1:0] buf_a[$];
  logic [DATA_W-1:0] buf_d[$];
  int                step = 0;
  int                wc = 0;
  // identification only by command, no elevated-voltage path
  // taken at the falling strobe: the controller moves address and data
  // in the very step where the strobe rises, so sampling there would race
  always @(negedge flash_we_n)
  begin
    if (flash_ce_n === 1'b0 && flash_dq_oe === 1'b1 && flash_oe_n === 1'b1)
    begin
      log_a.push_back(flash_addr);
      log_d.push_back(flash_dq_out);
      if (step == 3)
        wc = int'(flash_dq_out);
      if (step > 3 && step < wc + 5)
      begin
        buf_a.push_back(flash_addr);
        buf_d.push_back(flash_dq_out);
      end
      if (step == wc + 5 && flash_dq_out == CONFIRM_CODE)
      begin
        foreach (buf_a[i]) mem[buf_a[i]] = buf_d[i];
        buf_a.delete();
        buf_d.delete();
      end
      step = (step == wc + 5) ? 0 : step + 1;
    end
  end
endmodule // fwbce_flash_model

//--- fwbce_pkg.sv
// package for the flash write buffer command entry controller
package fwbce_pkg;
  localparam int unsigned ADDR_W        = 22;
  localparam int unsigned DATA_W        = 16;
  localparam int unsigned SECT_LSB      = 12;
  localparam logic [21:0] UNLOCK1_ADDR  = 22'h000555;
  localparam logic [21:0] UNLOCK2_ADDR  = 22'h0002aa;
  localparam logic [15:0] UNLOCK1_CODE  = 16'h00aa;
  localparam logic [15:0] UNLOCK2_CODE  = 16'h0055;
  localparam logic [15:0] BUF_LOAD_CODE = 16'h0025;
  localparam logic [15:0] CONFIRM_CODE  = 16'h0029;
  localparam int unsigned CLK_MHZ       = 200;
  localparam int unsigned STROBE_NS     = 35;
  localparam int unsigned SETUP_NS      = 5;
  localparam int unsigned STROBE_CYC    = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SETUP_CYC     = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam logic [4:0]  CNT_ONE       = 5'h01;
  localparam logic [4:0]  CNT_ZERO      = 5'h00;

  typedef enum logic [2:0] {
    FWBCE_IDLE   = 3'b000,
    FWBCE_UNLK1  = 3'b001,
    FWBCE_UNLK2  = 3'b011,
    FWBCE_CMD    = 3'b010,
    FWBCE_COUNT  = 3'b110,
    FWBCE_LOAD   = 3'b111,
    FWBCE_CONF   = 3'b101,
    FWBCE_WAITW  = 3'b100
  } fwbce_state_t;
endpackage
